// file: hw/fcs_pkg.sv
// Constants, states and helpers for the fanout switch control block.
// Assumes a single 100 MHz system clock and synchronous active-low reset.
package fcs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] SW_ROUTE_OFS   = 8'h00;
    localparam logic [7:0] COMP_PIN_OFS   = 8'h01;
    localparam logic [7:0] SW_ROUTE_RST   = 8'h00;
    localparam logic [7:0] COMP_PIN_RST   = 8'haa;
    localparam logic [7:0] SW_ROUTE_WMASK = 8'hfc;

    // ----------------------------------------------------------------
    // Field positions of the route register
    // ----------------------------------------------------------------
    localparam int B_EN_BIT  = 7;
    localparam int B_SEL_HI  = 6;
    localparam int B_SEL_LO  = 5;
    localparam int A_EN_BIT  = 4;
    localparam int A_SEL_HI  = 3;
    localparam int A_SEL_LO  = 2;

    // ----------------------------------------------------------------
    // Bus and pin constants
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_FIXED  = 4'h7;
    localparam int         ADDR_PINS   = 3;
    localparam int         PORTS       = 4;
    localparam int         COMP_PINS   = 4;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [3:0] LAST_BIT    = 4'h7;
    localparam int         SYNC_WIDTH  = 12;
    localparam logic [11:0] SYNC_RST   = 12'h003;

    typedef enum logic [3:0] {
        ST_IDLE, ST_DEV, ST_ACK_DEV, ST_PTR, ST_ACK_PTR,
        ST_WR, ST_ACK_WR, ST_RD, ST_RACK
    } fcs_state_e;

    // One-hot port choice for a bank, empty when the bank is off
    function automatic logic [3:0] fcs_onehot(input logic en, input logic [1:0] sel);
        fcs_onehot = en ? (4'h1 << sel) : 4'h0;
    endfunction

endpackage

// file: hw/fcs_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/100ps
module fcs_sync #(
    parameter int              WIDTH     = 12,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Pins in, synchronised out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            meta <= RESET_VAL;
            q    <= RESET_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// file: hw/fcs_top.sv
// Control logic of a 2:4 fanout switch: bus target, two registers, routing.
// Assumes the bus lines and all pins are asynchronous and are oversampled
// by sys_clk; bus clock must stay well below a quarter of sys_clk.
//
// Summary of operation
// R1: Reset loads route 00h, companion AAh
// R2: Route register zero leaves both banks open in mode 1
// R3: Companion value AAh floats all four pins
// R4: Mode 0 routes from the six pins
// R5: Mode 1 routes from register, pins drive
// R6: Bank A enable gates its port choice
// R7: Bank B enable gates its port choice
// R8: Two select bits pick port zero-three
// R9: Same port: bank A wins, B open
// R10: Route register field layout at 00h
// R11: Pin n: bit 2n+1 float, 2n value
// R12: Target address 0111 plus three pins
// R13: Address byte first, last bit read/write
// R14: Repeated start accepted in any state
// R15: Route low two bits ignore writes, read 0
// R16: Both registers read back their contents
// R17: Pointer byte then data bytes stored
// R18: Routing updates on acked byte, glitch-free
`timescale 1ns/100ps
module fcs_top
    import fcs_pkg::*;
(
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    // Configuration pins
    input  wire logic                 mode_pin,
    input  wire logic [ADDR_PINS-1:0] target_address_pins,
    // Bus lines, data open-drain
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe_n,
    // Direct-control pins, inputs side
    input  wire logic                 direct_a_select_lo_pin,
    input  wire logic                 direct_a_select_hi_pin,
    input  wire logic                 direct_a_enable_pin,
    input  wire logic                 direct_b_select_lo_pin,
    input  wire logic                 direct_b_select_hi_pin,
    input  wire logic                 direct_b_enable_pin,
    // Companion pins, output side of pins 0..3
    output logic [COMP_PINS-1:0]      companion_out,
    output logic [COMP_PINS-1:0]      companion_oe_n,
    // Switch connections, one-hot per bank
    output logic [PORTS-1:0]          bank_a_to_port,
    output logic [PORTS-1:0]          bank_b_to_port
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic                  scl_s;
    logic                  sda_s;
    logic                  mode_s;
    logic [ADDR_PINS-1:0]  addr_s;
    logic                  dir_a_lo_s;
    logic                  dir_a_hi_s;
    logic                  dir_a_en_s;
    logic                  dir_b_lo_s;
    logic                  dir_b_hi_s;
    logic                  dir_b_en_s;
    logic                  scl_d;
    logic                  sda_d;

    fcs_sync #(
        .WIDTH     (SYNC_WIDTH),
        .RESET_VAL (SYNC_RST)
    ) u_sync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .d       ({direct_b_enable_pin, direct_b_select_hi_pin, direct_b_select_lo_pin,
                   direct_a_enable_pin, direct_a_select_hi_pin, direct_a_select_lo_pin,
                   target_address_pins, mode_pin, sda_in, scl_in}),
        .q       ({dir_b_en_s, dir_b_hi_s, dir_b_lo_s, dir_a_en_s, dir_a_hi_s, dir_a_lo_s,
                   addr_s, mode_s, sda_s, scl_s})
    );

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    // Data edges only count while the clock is steady high
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

    // ----------------------------------------------------------------
    // Registers and read mux
    // ----------------------------------------------------------------
    logic [7:0] route_reg;
    logic [7:0] comp_reg;

    // Unmapped pointers read as zero
    function automatic logic [7:0] fcs_read(input logic [7:0] p, input logic [7:0] route_v,
                                            input logic [7:0] comp_v);
        fcs_read = (p == SW_ROUTE_OFS) ? (route_v & SW_ROUTE_WMASK) :      // [R15] [R16]
                   (p == COMP_PIN_OFS) ? comp_v : 8'h00;                  // [R16]
    endfunction

    // ----------------------------------------------------------------
    // Bus target state machine
    // ----------------------------------------------------------------
    fcs_state_e state;
    fcs_state_e next_state;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic       next_sda_oe_n;
    logic       wr_en;
    logic       rx_state;
    logic       byte_done;
    logic       addr_hit;
    logic [7:0] ptr_inc;

    assign rx_state  = (state == ST_DEV) | (state == ST_PTR) | (state == ST_WR);
    assign byte_done = (bit_cnt == BYTE_BITS);
    assign addr_hit  = (shreg[7:1] == {ADDR_FIXED, addr_s});                // [R12] [R13]
    assign ptr_inc   = 8'(ptr + 8'h01);

    always_comb begin
        next_state    = state;
        next_bit_cnt  = bit_cnt;
        next_shreg    = shreg;
        next_ptr      = ptr;
        next_sda_oe_n = sda_oe_n;
        wr_en         = 1'b0;
        if (bus_start) begin
            // Restart from any state, no stop needed
            next_state    = ST_DEV;                                         // [R14]
            next_bit_cnt  = 4'h0;
            next_sda_oe_n = 1'b1;
        end else if (bus_stop) begin
            next_state    = ST_IDLE;
            next_sda_oe_n = 1'b1;
        end else if (rx_state && scl_rise) begin
            next_shreg   = {shreg[6:0], sda_s};
            next_bit_cnt = 4'(bit_cnt + 4'h1);
        end else if (scl_fall) begin
            unique case (state)
                ST_IDLE: ;
                ST_DEV: begin
                    if (byte_done) begin
                        next_bit_cnt  = 4'h0;
                        next_state    = addr_hit ? ST_ACK_DEV : ST_IDLE;    // [R12]
                        next_sda_oe_n = ~addr_hit;
                    end
                end
                ST_ACK_DEV: begin
                    next_bit_cnt = 4'h0;
                    if (shreg[0]) begin
                        // Read: first data bit goes out on this fall
                        next_state    = ST_RD;                              // [R13]
                        next_shreg    = fcs_read(ptr, route_reg, comp_reg);
                        next_sda_oe_n = next_shreg[7];
                    end else begin
                        next_state    = ST_PTR;                             // [R13]
                        next_sda_oe_n = 1'b1;
                    end
                end
                ST_PTR: begin
                    if (byte_done) begin
                        next_bit_cnt  = 4'h0;
                        next_ptr      = shreg;                              // [R17]
                        next_state    = ST_ACK_PTR;
                        next_sda_oe_n = 1'b0;
                    end
                end
                ST_ACK_PTR: begin
                    next_state    = ST_WR;
                    next_sda_oe_n = 1'b1;
                end
                ST_WR: begin
                    if (byte_done) begin
                        next_bit_cnt  = 4'h0;
                        wr_en         = 1'b1;                               // [R17] [R18]
                        next_state    = ST_ACK_WR;
                        next_sda_oe_n = 1'b0;
                    end
                end
                ST_ACK_WR: begin
                    next_ptr      = ptr_inc;
                    next_state    = ST_WR;
                    next_sda_oe_n = 1'b1;
                end
                ST_RD: begin
                    next_bit_cnt = 4'(bit_cnt + 4'h1);
                    if (bit_cnt == LAST_BIT) begin
                        next_state    = ST_RACK;
                        next_sda_oe_n = 1'b1;
                    end else begin
                        next_shreg    = {shreg[6:0], 1'b0};
                        next_sda_oe_n = shreg[6];
                    end
                end
                ST_RACK: begin
                    // Controller acked: move on to the next register
                    next_bit_cnt  = 4'h0;
                    next_ptr      = ptr_inc;                                // [R16]
                    next_state    = ST_RD;
                    next_shreg    = fcs_read(ptr_inc, route_reg, comp_reg);
                    next_sda_oe_n = next_shreg[7];
                end
            endcase
        end else if (state == ST_RACK && scl_rise && sda_s) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state    <= ST_IDLE;
            bit_cnt  <= 4'h0;
            shreg    <= 8'h00;
            ptr      <= 8'h00;
            sda_oe_n <= 1'b1;
            sda_out  <= 1'b0;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            state    <= next_state;
            bit_cnt  <= next_bit_cnt;
            shreg    <= next_shreg;
            ptr      <= next_ptr;
            sda_oe_n <= next_sda_oe_n;
            sda_out  <= 1'b0;
            scl_d    <= scl_s;
            sda_d    <= sda_s;
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            route_reg <= SW_ROUTE_RST;                                      // [R1]
            comp_reg  <= COMP_PIN_RST;                                      // [R1]
        end else if (wr_en && ptr == SW_ROUTE_OFS) begin
            route_reg <= shreg & SW_ROUTE_WMASK;                            // [R10] [R15]
        end else if (wr_en && ptr == COMP_PIN_OFS) begin
            comp_reg  <= shreg;                                             // [R11]
        end
    end

    // ----------------------------------------------------------------
    // Routing and companion pins
    // ----------------------------------------------------------------
    logic                 a_en;
    logic                 b_en;
    logic [1:0]           a_sel;
    logic [1:0]           b_sel;
    logic [PORTS-1:0]     next_a_to_port;
    logic [PORTS-1:0]     next_b_to_port;
    logic [COMP_PINS-1:0] next_comp_out;
    logic [COMP_PINS-1:0] next_comp_oe_n;

    assign a_en  = mode_s ? route_reg[A_EN_BIT] : dir_a_en_s;                         // [R4] [R5]
    assign b_en  = mode_s ? route_reg[B_EN_BIT] : dir_b_en_s;                         // [R4] [R5]
    assign a_sel = mode_s ? route_reg[A_SEL_HI:A_SEL_LO] : {dir_a_hi_s, dir_a_lo_s};  // [R10]
    assign b_sel = mode_s ? route_reg[B_SEL_HI:B_SEL_LO] : {dir_b_hi_s, dir_b_lo_s};  // [R10]
    assign next_a_to_port = fcs_onehot(a_en, a_sel);                                  // [R2] [R6] [R8]
    // Bank A takes a shared port first
    assign next_b_to_port = fcs_onehot(b_en, b_sel) & ~next_a_to_port;                // [R7] [R9]

    always_comb begin
        next_comp_out  = '0;
        next_comp_oe_n = '1;
        for (int n = 0; n < COMP_PINS; n++) begin
            next_comp_out[n]  = comp_reg[2*n];                              // [R11]
            // Mode 0 keeps the pins as inputs
            next_comp_oe_n[n] = ~mode_s | comp_reg[2*n+1];                  // [R3] [R5]
        end
    end

    // Registered so a multi-bit change never shows a half-decoded route
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            bank_a_to_port <= '0;
            bank_b_to_port <= '0;
            companion_out  <= '0;
            companion_oe_n <= '1;
        end else begin
            bank_a_to_port <= next_a_to_port;                               // [R18]
            bank_b_to_port <= next_b_to_port;                               // [R18]
            companion_out  <= next_comp_out;
            companion_oe_n <= next_comp_oe_n;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    reset_values_a: assert property ($rose(resetn) |-> route_reg == 8'h00 && comp_reg == 8'haa) // [R1]
        else $error("Registers not at reset values");
    zero_route_a: assert property ((mode_s && route_reg == 8'h00) ##1 mode_s |-> bank_a_to_port == 4'h0 && bank_b_to_port == 4'h0) // [R2]
        else $error("Bank connected with zero route");
    float_pins_a: assert property (comp_reg == 8'haa |=> companion_oe_n == 4'hf) // [R3]
        else $error("Companion pin driven at aa");
    direct_mode_a: assert property ((!mode_s && dir_a_en_s && {dir_a_hi_s, dir_a_lo_s} == 2'h2) |=> bank_a_to_port == 4'h4) // [R4]
        else $error("Direct pins not routing bank A");
    drive_mode_a: assert property ((mode_s && !comp_reg[1]) |=> !companion_oe_n[0] && companion_out[0] == $past(comp_reg[0])) // [R5]
        else $error("Companion pin 0 not driven in mode 1");
    bank_a_off_a: assert property (!a_en |=> bank_a_to_port == 4'h0) // [R6]
        else $error("Bank A connected while disabled");
    bank_b_sel_a: assert property ((b_en && !(a_en && a_sel == b_sel)) |=> bank_b_to_port == (4'h1 << $past(b_sel))) // [R7]
        else $error("Bank B port mismatch");
    port_map_a: assert property ((mode_s && route_reg[4:2] == 3'h7) ##1 mode_s |-> bank_a_to_port == 4'h8) // [R8]
        else $error("Select 11 did not pick port 3");
    bank_prio_a: assert property ((a_en && b_en && a_sel == b_sel) |=> bank_b_to_port == 4'h0 && bank_a_to_port != 4'h0) // [R9]
        else $error("Bank B shares port with A");
    low_bits_a: assert property (route_reg[1:0] == 2'h0) // [R15]
        else $error("Route low bits not zero");
    addr_ack_a: assert property ((state == ST_DEV && next_state == ST_ACK_DEV) |-> shreg[7:4] == 4'h7 && shreg[3:1] == addr_s) // [R12]
        else $error("Acked a foreign address");
    restart_a: assert property (bus_start |=> state == ST_DEV && bit_cnt == 4'h0 && sda_oe_n) // [R14]
        else $error("Repeated start not taken");
    write_store_a: assert property ((wr_en && ptr == COMP_PIN_OFS) |=> comp_reg == $past(shreg)) // [R17]
        else $error("Data byte not stored");
    read_load_a: assert property ((state == ST_ACK_DEV && scl_fall && shreg[0] && !bus_start && !bus_stop) |=> shreg == fcs_read(ptr, route_reg, comp_reg)) // [R16]
        else $error("Read byte not loaded from register");

    write_route_c: cover property (wr_en && ptr == SW_ROUTE_OFS);
    read_back_c:   cover property (state == ST_RD ##[1:1000] state == ST_RACK);
    restart_c:     cover property (state == ST_PTR ##[1:1000] bus_start);
    conflict_c:    cover property (a_en && b_en && a_sel == b_sel);

endmodule

// file: test/fcs_i2c_ctrl.sv
// Behavioural bus controller that drives the clock and data lines of the target.
// Assumes a pull-up on the data line; the target can only pull it low.
`timescale 1ns/100ps
module fcs_i2c_ctrl (
    // Clock
    input  wire logic sys_clk,
    // Target side of the data line
    input  wire logic sda_oe_n,
    input  wire logic sda_out,
    // Bus lines as the target sees them
    output logic      scl,
    output logic      sda
);
    logic sda_drv;

    // ------------------------------------------------------------
    // Wired-AND line with pull-up
    // ------------------------------------------------------------
    assign sda = sda_drv && !(sda_oe_n === 1'b0 && sda_out === 1'b0);

    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    // ------------------------------------------------------------
    // Bus phases, quarter of a bit each
    // ------------------------------------------------------------
    // Four cycles per quarter keeps both clock phases above the minimum
    task automatic q;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    // Also serves as repeated start from a low clock phase
    task automatic start;
        sda_drv = 1'b1;
        q;
        scl = 1'b1;
        q;
        sda_drv = 1'b0;
        q;
        scl = 1'b0;
    endtask

    task automatic stop;
        q;
        sda_drv = 1'b0;
        q;
        scl = 1'b1;
        q;
        sda_drv = 1'b1;
        q;
    endtask

    // Data moves a quarter after the clock falls, never beside an edge
    task automatic bit_io(input logic b, output logic r);
        q;
        sda_drv = b;
        q;
        scl = 1'b1;
        q;
        q;
        r   = sda;
        scl = 1'b0;
    endtask

    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack_out);
    endtask
endmodule

// file: test/test_fanout_switch_control.sv
// Self-checking bench: pins and bus stimulus, compared with a reference model.
// Assumes fcs_i2c_ctrl as bus controller and the design package fcs_pkg.
`timescale 1ns/100ps
`define FCS_CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_fanout_switch_control
    import fcs_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    logic        sys_clk;
    logic        resetn;
    logic        mode_pin;
    logic [2:0]  adr;
    logic [5:0]  dir;
    logic [7:0]  rx;
    logic        ack;
    logic [31:0] rnd;
    logic [7:0]  m0;
    logic [7:0]  m1;
    wire         scl;
    wire         sda;
    wire         sda_out;
    wire         sda_oe_n;
    wire  [3:0]  comp_out;
    wire  [3:0]  comp_oe_n;
    wire  [3:0]  a_port;
    wire  [3:0]  b_port;
    int          failures;
    int          checks;
    int          seed;

    fcs_top u_fcs_top (
        .sys_clk                (sys_clk),
        .resetn                 (resetn),
        .mode_pin               (mode_pin),
        .target_address_pins    (adr),
        .scl_in                 (scl),
        .sda_in                 (sda),
        .sda_out                (sda_out),
        .sda_oe_n               (sda_oe_n),
        .direct_a_select_lo_pin (dir[0]),
        .direct_a_select_hi_pin (dir[1]),
        .direct_a_enable_pin    (dir[2]),
        .direct_b_select_lo_pin (dir[3]),
        .direct_b_select_hi_pin (dir[4]),
        .direct_b_enable_pin    (dir[5]),
        .companion_out          (comp_out),
        .companion_oe_n         (comp_oe_n),
        .bank_a_to_port         (a_port),
        .bank_b_to_port         (b_port)
    );

    fcs_i2c_ctrl u_fcs_i2c_ctrl (
        .sys_clk  (sys_clk),
        .sda_oe_n (sda_oe_n),
        .sda_out  (sda_out),
        .scl      (scl),
        .sda      (sda)
    );

    // ------------------------------------------------------------
    // Reference model and bus tasks
    // ------------------------------------------------------------
    task automatic expect_pins;
        logic       ea;
        logic       eb;
        logic [1:0] sa;
        logic [1:0] sb;
        logic [3:0] xa;
        logic [3:0] xb;
        logic [3:0] xoe;
        logic [3:0] xo;
        ea = mode_pin ? m0[4] : dir[2];
        sa = mode_pin ? m0[3:2] : dir[1:0];
        eb = mode_pin ? m0[7] : dir[5];
        sb = mode_pin ? m0[6:5] : dir[4:3];
        xa = ea ? 4'h1 << sa : 4'h0;
        xb = (eb && !(ea && sa == sb)) ? 4'h1 << sb : 4'h0;
        for (int n = 0; n < 4; n++) begin
            xoe[n] = !mode_pin || m1[2*n+1];
            xo[n]  = m1[2*n];
        end
        // Two sync flops and one output flop before pins show
        repeat (4) @(posedge sys_clk);
        #1;
        `FCS_CHK(a_port, xa)
        `FCS_CHK(b_port, xb)
        `FCS_CHK(comp_oe_n, xoe)
        `FCS_CHK(comp_out, xo)
    endtask

    task automatic store(input logic [7:0] p, input logic [7:0] d);
        if (p == 8'h00) m0 = d & 8'hfc;
        if (p == 8'h01) m1 = d;
    endtask

    function automatic logic [7:0] peek(input logic [7:0] p);
        peek = (p == 8'h00) ? m0 : (p == 8'h01) ? m1 : 8'h00;
    endfunction

    task automatic send(input logic [7:0] b, input logic nack);
        u_fcs_i2c_ctrl.xfer(b, 1'b1, rx, ack);
        `FCS_CHK(ack, nack)
    endtask

    task automatic wr2(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
        u_fcs_i2c_ctrl.start();
        send({4'h7, adr, 1'b0}, 1'b0);
        send(p, 1'b0);
        send(d0, 1'b0);
        send(d1, 1'b0);
        u_fcs_i2c_ctrl.stop();
        store(p, d0);
        store(p + 8'h01, d1);
        expect_pins;
    endtask

    task automatic rd2(input logic [7:0] p);
        u_fcs_i2c_ctrl.start();
        send({4'h7, adr, 1'b0}, 1'b0);
        send(p, 1'b0);
        u_fcs_i2c_ctrl.start();
        send({4'h7, adr, 1'b1}, 1'b0);
        u_fcs_i2c_ctrl.xfer(8'hff, 1'b0, rx, ack);
        `FCS_CHK(rx, peek(p))
        u_fcs_i2c_ctrl.xfer(8'hff, 1'b1, rx, ack);
        `FCS_CHK(rx, peek(p + 8'h01))
        u_fcs_i2c_ctrl.stop();
    endtask

    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        failures++;
        wrap_up;
    end

    initial begin
        seed     = 32'hbb03;
        failures = 0;
        checks   = 0;
        resetn   = 1'b0;
        mode_pin = 1'b1;
        adr      = 3'h0;
        dir      = 6'h00;
        m0       = 8'h00;
        m1       = 8'haa;
        repeat (4) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        expect_pins;
        rd2(8'h00);
        for (int i = 0; i < 24; i++) begin
            rnd = $random(seed);
            adr = rnd[2:0];
            dir = rnd[8:3];
            // Direct pins wander in mode 1 and must not steer
            if (i < 4)
                wr2(8'h00, {1'b1, i[1:0], 1'b1, i[1:0], 2'b11}, 8'haa);
            else
                wr2({7'h00, rnd[9]}, rnd[17:10], rnd[25:18]);
            rd2({6'h00, rnd[27:26]});
        end
        mode_pin = 1'b0;
        for (int i = 0; i < 64; i++) begin
            dir = i[5:0];
            expect_pins;
        end
        mode_pin = 1'b1;
        expect_pins;
        // Second reset after writes must bring back the defaults
        resetn = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        m0     = 8'h00;
        m1     = 8'haa;
        expect_pins;
        u_fcs_i2c_ctrl.start();
        send({4'h6, adr, 1'b0}, 1'b1);
        u_fcs_i2c_ctrl.stop();
        u_fcs_i2c_ctrl.start();
        send({4'h7, adr ^ 3'h5, 1'b0}, 1'b1);
        u_fcs_i2c_ctrl.stop();
        rd2(8'h00);
        wrap_up;
    end
endmodule
